// ---- logic/link_diag_pkg.sv ----
// constants shared by the link diagnostics block
// assumes frames reach the block already de-framed, one byte per beat
`default_nettype none
package link_diag_pkg;
	localparam logic [15:0] TEST_REQ_CLUSTER   = 16'h0014;
	localparam logic [15:0] TEST_RES_CLUSTER   = 16'h0094;
	localparam logic [7:0]  DIAG_ENDPOINT      = 8'hE6;
	localparam logic [7:0]  FRAME_EXPLICIT_RX  = 8'h91;
	localparam logic [7:0]  FRAME_CMD_RESPONSE = 8'h88;
	localparam logic [7:0]  RESULT_OK          = 8'h00;
	localparam logic [7:0]  RESULT_BAD_PARAM   = 8'h03;
	localparam logic [4:0]  REQ_PAYLOAD_BYTES  = 5'd12;
	localparam logic [4:0]  RESULT_BYTES       = 5'd21;
	localparam logic [15:0] MIN_ITERATIONS     = 16'h0001;
	localparam logic [15:0] MAX_ITERATIONS     = 16'h0FA0;
	localparam logic [7:0]  DISC_WINDOW_RESET  = 8'h82;
	// one step of the discovery window, in ms, and the clock rate
	localparam int          DISC_STEP_MS       = 100;
	localparam int          CLOCK_KHZ          = 125000;
	localparam int          DISC_STEP_CYCLES   = DISC_STEP_MS * CLOCK_KHZ;
	localparam logic [15:0] LFSR_SEED          = 16'hACE1;
	typedef enum logic [2:0] {
		ST_IDLE, ST_PARSE, ST_CHECK, ST_SEND, ST_WAIT, ST_DIVIDE, ST_EMIT
	} test_state_t;
endpackage
`default_nettype wire

// ---- logic/mesh_link_diagnostics.sv ----
// link test engine, signal readout, discovery and neighbour search
// assumes framing is removed upstream and the radio acknowledges each test packet
`default_nettype none
module mesh_link_diagnostics
	import link_diag_pkg::*;
#(
	parameter logic [15:0] MAX_PAYLOAD = 16'h0100,
	parameter int          STEP_CYCLES = link_diag_pkg::DISC_STEP_CYCLES
) (
	// clock and reset
	input  wire logic                      clock,
	input  wire logic                      arst_n,
	// own identity and settings
	input  wire logic [63:0]               serial_number_high_low,
	input  wire logic [7:0]                retry_limit,
	input  wire logic                      window_write,
	input  wire logic [7:0]                window_data,
	// incoming request payload stream from the radio
	input  wire logic                      req_valid,
	output logic                           req_ready,
	input  wire logic [7:0]                req_data,
	input  wire logic                      req_last,
	input  wire logic [15:0]               req_cluster,
	input  wire logic [7:0]                req_endpoint,
	input  wire logic [63:0]               req_source,
	// test packet transmit and acknowledge
	output logic                           tx_valid,
	input  wire logic                      tx_ready,
	output logic [63:0]                    tx_dest,
	output logic [15:0]                    tx_size,
	input  wire logic                      tx_done,
	input  wire logic                      tx_acked,
	input  wire logic [7:0]                tx_retries,
	input  wire logic [7:0]                tx_rssi,
	// result record stream to the radio
	output logic                           res_valid,
	input  wire logic                      res_ready,
	output logic [7:0]                     res_data,
	output logic                           res_last,
	output logic [63:0]                    res_dest,
	output logic [15:0]                    res_cluster,
	output logic [7:0]                     res_endpoint,
	// received packets
	input  wire logic                      rx_packet,
	input  wire logic [7:0]                rx_rssi,
	input  wire logic [15:0]               rx_cluster,
	input  wire logic [7:0]                rx_endpoint,
	input  wire logic [63:0]               rx_source,
	// signal readout
	output logic [7:0]                     last_signal_query,
	output logic                           signal_pwm,
	// host report frames
	output logic                           host_frame_valid,
	output logic [7:0]                     host_frame_type,
	output logic [63:0]                    host_frame_addr,
	// network discovery
	input  wire logic                      network_discovery_command,
	output logic                           disc_broadcast,
	output logic [7:0]                     discovery_delay_window,
	input  wire logic                      disc_request,
	input  wire logic [7:0]                disc_request_window,
	output logic                           disc_answer,
	output logic [63:0]                    disc_answer_addr,
	// neighbour search
	input  wire logic                      neighbour_search_command,
	input  wire logic                      search_remote,
	input  wire logic [63:0]               search_requester,
	output logic                           search_broadcast,
	output logic [63:0]                    search_reply_to,
	input  wire logic                      search_query,
	input  wire logic [63:0]               search_query_reply_to,
	output logic                           search_reply,
	output logic [63:0]                    search_reply_dest,
	input  wire logic                      search_reply_in,
	input  wire logic [63:0]               search_reply_source
);
	import link_diag_pkg::*;

	test_state_t state;
	test_state_t next_state;
	logic [95:0] req_shift;
	logic [4:0]  req_count;
	logic        req_match;
	logic [63:0] requester;
	logic [15:0] sent;
	logic [15:0] acked;
	logic [15:0] retries;
	logic [7:0]  rssi_max;
	logic [7:0]  rssi_min;
	logic [23:0] rssi_rem;
	logic [7:0]  rssi_avg;
	logic [7:0]  result_code;
	logic [4:0]  emit_index;
	logic [7:0]  pwm_count;

	// request fields, in payload order
	wire [63:0] target     = req_shift[95:32];
	wire [15:0] pkt_size   = req_shift[31:16];
	wire [15:0] iterations = req_shift[15:0];
	wire        req_take   = req_valid && req_ready;
	wire        is_test_req = (req_cluster == TEST_REQ_CLUSTER) &&
	                          (req_endpoint == DIAG_ENDPOINT);
	wire        params_ok  = (req_count == REQ_PAYLOAD_BYTES) &&
	                         (iterations >= MIN_ITERATIONS) &&
	                         (iterations <= MAX_ITERATIONS) &&
	                         (pkt_size != 16'h0000) && (pkt_size <= MAX_PAYLOAD);
	wire        tx_take    = tx_valid && tx_ready;
	wire        last_pkt   = (sent == iterations);
	wire        div_step   = (acked != 16'h0000) && (rssi_rem >= {8'h00, acked}) &&
	                         (rssi_avg != 8'hFF);
	wire        buf_ready;
	wire        emit_push  = (state == ST_EMIT);
	wire        emit_take  = emit_push && buf_ready;
	wire        emit_final = (emit_index == RESULT_BYTES - 5'd1);
	wire [15:0] retries_sum = retries + {8'h00, tx_retries};
	wire [23:0] rssi_sum    = rssi_rem + {16'h0000, tx_rssi};

	wire [167:0] record = {target, pkt_size, sent, acked, retries,
	                       result_code, retry_limit, rssi_max, rssi_min, rssi_avg};
	wire [7:0]   record_byte = record[8'd167 - {emit_index, 3'b000} -: 8];

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (req_take) begin
					next_state = req_last ? (is_test_req ? ST_CHECK : ST_IDLE) : ST_PARSE;
				end
			end
			ST_PARSE: begin
				if (req_take && req_last) begin
					next_state = req_match ? ST_CHECK : ST_IDLE;
				end
			end
			ST_CHECK: begin
				next_state = params_ok ? ST_SEND : ST_EMIT;
			end
			ST_SEND: begin
				if (tx_take) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (tx_done) begin
					next_state = last_pkt ? ST_DIVIDE : ST_SEND;
				end
			end
			ST_DIVIDE: begin
				if (!div_step) begin
					next_state = ST_EMIT;
				end
			end
			ST_EMIT: begin
				if (emit_take && emit_final) begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state     <= ST_IDLE;
			req_ready <= 1'b1;
			tx_valid  <= 1'b0;
		end else begin
			state     <= next_state;
			req_ready <= (next_state == ST_IDLE) || (next_state == ST_PARSE);
			tx_valid  <= (next_state == ST_SEND);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			req_shift <= '0;
			req_count <= '0;
			req_match <= 1'b0;
			requester <= '0;
		end else if (req_take) begin
			req_shift <= {req_shift[87:0], req_data};
			req_count <= (state == ST_IDLE) ? 5'd1 :
			             (req_count == 5'd31) ? req_count : req_count + 5'd1;
			if (state == ST_IDLE) begin
				req_match <= is_test_req;
				requester <= req_source;
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tx_dest <= '0;
			tx_size <= '0;
		end else if (state == ST_CHECK) begin
			tx_dest <= target;
			tx_size <= pkt_size;
		end
	end

	// statistics gathering and averaging
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sent        <= '0;
			acked       <= '0;
			retries     <= '0;
			rssi_max    <= 8'hFF;
			rssi_min    <= 8'h00;
			rssi_rem    <= '0;
			rssi_avg    <= '0;
			result_code <= RESULT_OK;
		end else begin
			if (state == ST_CHECK) begin
				sent        <= '0;
				acked       <= '0;
				retries     <= '0;
				rssi_max    <= 8'hFF;
				rssi_min    <= 8'h00;
				rssi_rem    <= '0;
				rssi_avg    <= '0;
				result_code <= params_ok ? RESULT_OK : RESULT_BAD_PARAM;
			end
			if (tx_take) begin
				sent <= sent + 16'h0001;
			end
			if (state == ST_WAIT && tx_done) begin
				retries <= (retries_sum < retries) ? 16'hFFFF : retries_sum;
				if (tx_acked) begin
					acked    <= acked + 16'h0001;
					rssi_rem <= rssi_sum;
					// smaller magnitude means a stronger signal
					if (tx_rssi < rssi_max) begin
						rssi_max <= tx_rssi;
					end
					if (tx_rssi > rssi_min) begin
						rssi_min <= tx_rssi;
					end
				end
			end
			if (state == ST_DIVIDE && div_step) begin
				rssi_rem <= rssi_rem - {8'h00, acked};
				rssi_avg <= rssi_avg + 8'h01;
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			emit_index <= '0;
		end else if (state != ST_EMIT) begin
			emit_index <= '0;
		end else if (emit_take) begin
			emit_index <= emit_index + 5'd1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			res_dest     <= '0;
			res_cluster  <= TEST_RES_CLUSTER;
			res_endpoint <= DIAG_ENDPOINT;
		end else if (state == ST_CHECK) begin
			res_dest     <= requester;
			res_cluster  <= TEST_RES_CLUSTER;
			res_endpoint <= DIAG_ENDPOINT;
		end
	end

	// record bytes pass a two-entry buffer so a receiver stall loses none
	pair_buffer #(
		.WIDTH (9)
	) result_buffer (
		.clock     (clock),
		.arst_n    (arst_n),
		.in_valid  (emit_push),
		.in_ready  (buf_ready),
		.in_data   ({emit_final, record_byte}),
		.out_valid (res_valid),
		.out_ready (res_ready),
		.out_data  ({res_last, res_data})
	);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			last_signal_query <= '0;
		end else if (rx_packet) begin
			last_signal_query <= rx_rssi;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pwm_count  <= '0;
			signal_pwm <= 1'b0;
		end else begin
			pwm_count  <= pwm_count + 8'h01;
			signal_pwm <= pwm_count < ~last_signal_query;
		end
	end

	// result and neighbour reports to host
	wire is_result = rx_packet && (rx_cluster == TEST_RES_CLUSTER) &&
	                 (rx_endpoint == DIAG_ENDPOINT);
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			host_frame_valid <= 1'b0;
			host_frame_type  <= '0;
			host_frame_addr  <= '0;
		end else begin
			host_frame_valid <= is_result || search_reply_in;
			if (is_result) begin
				host_frame_type <= FRAME_EXPLICIT_RX;
				host_frame_addr <= rx_source;
			end else if (search_reply_in) begin
				host_frame_type <= FRAME_CMD_RESPONSE;
				host_frame_addr <= search_reply_source;
			end
		end
	end

	// discovery: broadcast carries own window; answers wait a random share
	logic [15:0] rnd;
	logic [31:0] step_count;
	logic [7:0]  steps_left;
	logic        disc_pending;
	wire         step_end = (step_count == 32'(STEP_CYCLES - 1));

	random_source #(
		.WIDTH (16),
		.SEED  (LFSR_SEED)
	) delay_random (
		.clock  (clock),
		.arst_n (arst_n),
		.value  (rnd)
	);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			discovery_delay_window <= DISC_WINDOW_RESET;
			disc_broadcast         <= 1'b0;
		end else begin
			if (window_write) begin
				discovery_delay_window <= window_data;
			end
			disc_broadcast <= network_discovery_command;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			disc_pending     <= 1'b0;
			steps_left       <= '0;
			step_count       <= '0;
			disc_answer      <= 1'b0;
			disc_answer_addr <= '0;
		end else begin
			disc_answer <= 1'b0;
			if (disc_request && !disc_pending) begin
				disc_pending <= 1'b1;
				steps_left   <= rnd[7:0] & disc_request_window;
				step_count   <= '0;
			end else if (disc_pending) begin
				step_count <= step_end ? 32'd0 : step_count + 32'd1;
				if (steps_left == 8'h00) begin
					disc_pending     <= 1'b0;
					disc_answer      <= 1'b1;
					disc_answer_addr <= serial_number_high_low;
				end else if (step_end) begin
					steps_left <= steps_left - 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			search_broadcast  <= 1'b0;
			search_reply_to   <= '0;
			search_reply      <= 1'b0;
			search_reply_dest <= '0;
		end else begin
			search_broadcast <= neighbour_search_command;
			search_reply     <= search_query;
			if (neighbour_search_command) begin
				search_reply_to <= search_remote ? search_requester : serial_number_high_low;
			end
			if (search_query) begin
				search_reply_dest <= search_query_reply_to;
			end
		end
	end
endmodule
`default_nettype wire

// ---- logic/pair_buffer.sv ----
// two-entry valid/ready buffer; outputs come straight from flip-flops
// assumes one clock and the block reset
`default_nettype none
module pair_buffer #(
	parameter int WIDTH = 9
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             arst_n,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] spare;
	logic             spare_full;
	wire              take = in_valid && in_ready;
	wire              give = out_valid && out_ready;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			out_valid  <= 1'b0;
			out_data   <= '0;
			spare      <= '0;
			spare_full <= 1'b0;
			in_ready   <= 1'b1;
		end else begin
			if (give || !out_valid) begin
				out_valid  <= spare_full || take;
				out_data   <= spare_full ? spare : in_data;
				if (spare_full && take) begin
					spare <= in_data;
				end
				spare_full <= spare_full && take;
				in_ready   <= 1'b1;
			end else if (take) begin
				spare      <= in_data;
				spare_full <= 1'b1;
				in_ready   <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- logic/random_source.sv ----
// free running maximal-length lfsr giving a pseudo random word
// assumes one clock and the block reset
`default_nettype none
module random_source #(
	parameter int          WIDTH = 16,
	parameter logic [15:0] SEED  = 16'hACE1
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             arst_n,
	// random word
	output logic      [WIDTH-1:0] value
);
	wire feedback = value[15] ^ value[13] ^ value[12] ^ value[10];

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			value <= SEED[WIDTH-1:0];
		end else begin
			value <= {value[WIDTH-2:0], feedback};
		end
	end
endmodule
`default_nettype wire

// ---- verification/mesh_link_diagnostics_asserts.sv ----
// port checker for the link diagnostics block
// assumes one clock domain and a bind by port name
`default_nettype none
module diag_checker
	import link_diag_pkg::*;
(
	// clock and reset
	input wire logic        clock,
	input wire logic        arst_n,
	// watched ports
	input wire logic [63:0] serial_number_high_low,
	input wire logic        window_write,
	input wire logic [7:0]  window_data,
	input wire logic [7:0]  discovery_delay_window,
	input wire logic        network_discovery_command,
	input wire logic        disc_broadcast,
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	input wire logic [63:0] tx_dest,
	input wire logic [15:0] tx_size,
	input wire logic        res_valid,
	input wire logic        res_ready,
	input wire logic [7:0]  res_data,
	input wire logic        res_last,
	input wire logic [15:0] res_cluster,
	input wire logic [7:0]  res_endpoint,
	input wire logic        rx_packet,
	input wire logic [7:0]  rx_rssi,
	input wire logic [15:0] rx_cluster,
	input wire logic [7:0]  rx_endpoint,
	input wire logic [63:0] rx_source,
	input wire logic [7:0]  last_signal_query,
	input wire logic        host_frame_valid,
	input wire logic [7:0]  host_frame_type,
	input wire logic [63:0] host_frame_addr,
	input wire logic        neighbour_search_command,
	input wire logic        search_remote,
	input wire logic [63:0] search_requester,
	input wire logic        search_broadcast,
	input wire logic [63:0] search_reply_to
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	a_disc_bcast: assert property (
		network_discovery_command |=> disc_broadcast) else $error("no discovery broadcast");
	a_window_load: assert property (
		window_write |=> discovery_delay_window == $past(window_data)) else $error("window not set");
	a_search_local: assert property (
		neighbour_search_command && !search_remote |=> search_broadcast
		&& search_reply_to == serial_number_high_low) else $error("local search wrong");
	a_search_remote: assert property (
		neighbour_search_command && search_remote |=> search_broadcast
		&& search_reply_to == $past(search_requester)) else $error("remote search wrong");
	a_signal_last: assert property (
		rx_packet |=> last_signal_query == $past(rx_rssi)) else $error("signal not captured");
	a_result_frame: assert property (
		rx_packet && rx_cluster == TEST_RES_CLUSTER && rx_endpoint == DIAG_ENDPOINT
		|=> host_frame_valid && host_frame_type == FRAME_EXPLICIT_RX
		&& host_frame_addr == $past(rx_source)) else $error("result frame wrong");
	a_res_hold: assert property (
		res_valid && !res_ready |=> res_valid && $stable(res_data) && $stable(res_last))
		else $error("result byte not held");
	a_res_route: assert property (
		res_valid |-> res_cluster == TEST_RES_CLUSTER && res_endpoint == DIAG_ENDPOINT)
		else $error("result route wrong");
	a_tx_hold: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_dest) && $stable(tx_size))
		else $error("test packet not held");
	c_record_end: cover property (res_valid && res_ready && res_last);
	c_stall: cover property (res_valid && !res_ready);
	c_neighbour: cover property (host_frame_valid && host_frame_type == FRAME_CMD_RESPONSE);
endmodule
bind mesh_link_diagnostics diag_checker chk (.clock, .arst_n, .serial_number_high_low,
	.window_write, .window_data, .discovery_delay_window, .network_discovery_command,
	.disc_broadcast, .tx_valid, .tx_ready, .tx_dest, .tx_size, .res_valid, .res_ready,
	.res_data, .res_last, .res_cluster, .res_endpoint, .rx_packet, .rx_rssi, .rx_cluster,
	.rx_endpoint, .rx_source, .last_signal_query, .host_frame_valid, .host_frame_type,
	.host_frame_addr, .neighbour_search_command, .search_remote, .search_requester,
	.search_broadcast, .search_reply_to);
`default_nettype wire

// ---- verification/mesh_link_diagnostics_bench.sv ----
// bench for the link diagnostics block with the radio model beside it
// assumes the design package; discovery step shortened to 4 cycles
`default_nettype none
`define CHK(what, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %s expected %h seen %h", what, e, g); end end
module mesh_link_diagnostics_bench;
	import link_diag_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] serial_number_high_low, req_source, tx_dest, res_dest, rx_source;
	logic [63:0] host_frame_addr, disc_answer_addr, search_requester, search_reply_to;
	logic [63:0] search_query_reply_to, search_reply_dest, search_reply_source;
	logic [15:0] req_cluster, tx_size, res_cluster, rx_cluster, taken;
	logic [7:0]  retry_limit, window_data, req_data, req_endpoint, tx_retries, tx_rssi;
	logic [7:0]  res_data, res_endpoint, rx_rssi, rx_endpoint, last_signal_query;
	logic [7:0]  host_frame_type, discovery_delay_window, disc_request_window;
	logic        window_write, req_valid, req_ready, req_last, tx_valid, tx_ready, tx_done;
	logic        tx_acked, res_valid, res_ready, res_last, rx_packet, signal_pwm;
	logic        host_frame_valid, network_discovery_command, disc_broadcast, disc_request;
	logic        disc_answer, neighbour_search_command, search_remote, search_broadcast;
	logic        search_query, search_reply, search_reply_in, nack;
	logic        clock = 1'b0;
	logic        arst_n = 1'b0;
	int          failures = 0;
	int          n_checks = 0;
	int          pk_base = 0;
	int          hi;
	logic [73:0] exp_q[$];
	mesh_link_diagnostics #(.STEP_CYCLES(4)) uut (.*);
	radio_model partner (.*);
	always #4 clock = ~clock;
	always @(negedge clock) res_ready <= ($urandom % 4) != 0;
	task automatic stop_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		if (arst_n && res_valid && res_ready) begin
			if (exp_q.size() == 0) begin
				`CHK("stray_byte", 1'b0, 1'b1)
			end else begin
				if (exp_q[0][9]) `CHK("res_data", exp_q[0][7:0], res_data)
				`CHK("res_last", exp_q[0][8], res_last)
				`CHK("res_dest", exp_q[0][73:10], res_dest)
				void'(exp_q.pop_front());
			end
		end
	end
	task automatic strobe(ref logic s);
		@(negedge clock);
		s = 1'b1;
		@(negedge clock);
		s = 1'b0;
	endtask
	task automatic expect_rec(input logic [95:0] pay, input logic [7:0] code);
		logic [167:0] rec;
		logic [15:0]  ret;
		logic [7:0]   r, lo, st;
		int           sum, acked;
		ret = 16'h0000;
		sum = 0;
		st = 8'hFF;
		lo = 8'h00;
		acked = (nack || code != RESULT_OK) ? 0 : int'(pay[15:0]);
		for (int i = 0; code == RESULT_OK && i < int'(pay[15:0]); i++) begin
			r = 8'h50 + 8'((pk_base + i) % 4);
			ret += 16'((pk_base + i) % 4);
			if (!nack) sum += r;
			if (!nack && r < st) st = r;
			if (!nack && r > lo) lo = r;
		end
		rec = {pay, 16'(acked), ret, code, retry_limit, st, lo, 8'(acked > 0 ? sum / acked : 0)};
		for (int i = 0; i < 21; i++)
			exp_q.push_back({req_source, code == RESULT_OK || i == 16, i == 20, rec[167 - 8 * i -: 8]});
		if (code == RESULT_OK) pk_base += int'(pay[15:0]);
	endtask
	task automatic run(input logic [95:0] pay, input logic [15:0] cl, input logic [7:0] ep,
			input int nb, input logic [7:0] code);
		int w;
		@(negedge clock);
		req_cluster = cl;
		req_endpoint = ep;
		req_source = {$urandom, $urandom};
		for (int i = 0; i < nb; i++) begin
			req_valid = 1'b1;
			req_data = pay[95 - 8 * i -: 8];
			req_last = (i == nb - 1);
			w = 0;
			do begin @(posedge clock); w++; end while (!req_ready && w < 60000);
			if (w >= 60000) begin failures++; stop_test(); end
			@(negedge clock);
		end
		req_valid = 1'b0;
		if (cl == TEST_REQ_CLUSTER && ep == DIAG_ENDPOINT) expect_rec(pay, code);
	endtask
	task automatic drain();
		int w = 0;
		while ((exp_q.size() != 0 || !req_ready) && w < 60000) begin @(negedge clock); w++; end
		if (w >= 60000) begin failures++; stop_test(); end
		`CHK("packets", 16'(pk_base), taken)
	endtask
	initial begin
		void'($urandom(32'h075E80C8));
		{window_write, req_valid, req_last, rx_packet, network_discovery_command} = '0;
		{disc_request, neighbour_search_command, search_remote, search_query} = '0;
		{search_reply_in, nack, req_data, req_cluster, req_endpoint, req_source} = '0;
		{rx_rssi, rx_cluster, rx_endpoint, rx_source, window_data, disc_request_window} = '0;
		{search_requester, search_query_reply_to, search_reply_source} = '0;
		serial_number_high_low = {$urandom, $urandom};
		retry_limit = 8'($urandom);
		repeat (4) @(negedge clock);
		arst_n = 1'b1;
		`CHK("window_rst", DISC_WINDOW_RESET, discovery_delay_window)
		// valid counts, random and at both bounds, back to back
		for (int i = 0; i < 3; i++)
			run({$urandom, $urandom, 16'($urandom % 256 + 1), 16'($urandom % 9 + 2)},
				TEST_REQ_CLUSTER, DIAG_ENDPOINT, 12, RESULT_OK);
		run({64'h0, 16'h0100, 16'h0001}, TEST_REQ_CLUSTER, DIAG_ENDPOINT, 12, RESULT_OK);
		run({~64'h0, 16'h0001, 16'h0FA0}, TEST_REQ_CLUSTER, DIAG_ENDPOINT, 12, RESULT_OK);
		drain();
		`CHK("tx_dest", ~64'h0, tx_dest)
		`CHK("tx_size", 16'h0001, tx_size)
		run({64'h1, 16'h0028, 16'h0000}, TEST_REQ_CLUSTER, DIAG_ENDPOINT, 12, RESULT_BAD_PARAM);
		run({64'h2, 16'h0028, 16'h0FA1}, TEST_REQ_CLUSTER, DIAG_ENDPOINT, 12, RESULT_BAD_PARAM);
		run({64'h3, 16'h0000, 16'h0001}, TEST_REQ_CLUSTER, DIAG_ENDPOINT, 12, RESULT_BAD_PARAM);
		run({64'h4, 16'h0101, 16'h0001}, TEST_REQ_CLUSTER, DIAG_ENDPOINT, 12, RESULT_BAD_PARAM);
		run({64'h5, 16'h0028, 16'h0001}, TEST_REQ_CLUSTER, DIAG_ENDPOINT, 11, RESULT_BAD_PARAM);
		run({64'h6, 16'h0028, 16'h0001}, 16'h0012, DIAG_ENDPOINT, 12, RESULT_OK);
		run({64'h7, 16'h0028, 16'h0001}, TEST_REQ_CLUSTER, 8'hE8, 12, RESULT_OK);
		drain();
		nack = 1'b1;
		run({$urandom, $urandom, 16'h0040, 16'h0005}, TEST_REQ_CLUSTER, DIAG_ENDPOINT, 12, RESULT_OK);
		drain();
		nack = 1'b0;
		rx_rssi = 8'($urandom);
		rx_cluster = TEST_RES_CLUSTER;
		rx_endpoint = DIAG_ENDPOINT;
		rx_source = {$urandom, $urandom};
		strobe(rx_packet);
		`CHK("host_valid", 1'b1, host_frame_valid)
		`CHK("host_addr", rx_source, host_frame_addr)
		`CHK("signal", rx_rssi, last_signal_query)
		hi = 0;
		repeat (256) begin @(negedge clock); hi += int'(signal_pwm); end
		`CHK("pwm_duty", {1'b0, ~rx_rssi}, 9'(hi))
		strobe(search_reply_in);
		`CHK("host_type", FRAME_CMD_RESPONSE, host_frame_type)
		strobe(network_discovery_command);
		window_data = 8'h03;
		strobe(window_write);
		`CHK("window", 8'h03, discovery_delay_window)
		disc_request_window = 8'h03;
		strobe(disc_request);
		hi = 0;
		while (!disc_answer && hi < 15) begin @(negedge clock); hi++; end
		`CHK("disc_in_time", 1'b1, disc_answer)
		`CHK("disc_addr", serial_number_high_low, disc_answer_addr)
		search_requester = {$urandom, $urandom};
		search_remote = 1'b1;
		strobe(neighbour_search_command);
		search_remote = 1'b0;
		strobe(neighbour_search_command);
		search_query_reply_to = {$urandom, $urandom};
		strobe(search_query);
		`CHK("reply", 1'b1, search_reply)
		`CHK("reply_dest", search_query_reply_to, search_reply_dest)
		stop_test();
	end
endmodule
`default_nettype wire

// ---- verification/radio_model.sv ----
// behavioural radio that takes test packets and reports each acknowledge
// assumes the block clock and reset; packet k waits k mod 4 cycles
`default_nettype none
module radio_model (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        arst_n,
	// scenario control
	input  wire logic        nack,
	output logic      [15:0] taken,
	// test packet side
	input  wire logic        tx_valid,
	output logic             tx_ready,
	output logic             tx_done,
	output logic             tx_acked,
	output logic      [7:0]  tx_retries,
	output logic      [7:0]  tx_rssi
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       busy;
	logic       ack;
	logic [1:0] k;
	logic [1:0] wait_n;
	assign tx_ready   = !busy;
	assign tx_acked   = tx_done ? ack : !ack;
	assign tx_retries = tx_done ? {6'h00, k} : ~{6'h00, k};
	assign tx_rssi    = tx_done ? 8'h50 + {6'h00, k} : 8'hAF - {6'h00, k};
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			busy    <= 1'b0;
			ack     <= 1'b0;
			k       <= 2'h0;
			wait_n  <= 2'h0;
			taken   <= 16'h0000;
			tx_done <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			if (tx_valid && !busy) begin
				busy   <= 1'b1;
				k      <= taken[1:0];
				wait_n <= taken[1:0];
				ack    <= !nack;
				taken  <= taken + 16'h0001;
			end else if (busy && wait_n != 2'h0) begin
				wait_n <= wait_n - 2'h1;
			end else if (busy) begin
				busy    <= 1'b0;
				tx_done <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire
